// ---- shared/indirect_access_pkg.sv ----
/*
  Constants and types shared by the indirect data memory access logic.
  Assumes a processor core that issues one byte access per clock cycle.
*/
package indirect_access_pkg;

  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 9;
  localparam int unsigned SECTOR_COUNT = 2;

  localparam logic [8:0] IAR_A_ADDR    = 9'h000;
  localparam logic [8:0] PTR0_ADDR     = 9'h001;
  localparam logic [8:0] IAR_B_ADDR    = 9'h002;
  localparam logic [8:0] PTRB_LO_ADDR  = 9'h003;
  localparam logic [8:0] PTRB_SEC_ADDR = 9'h004;
  localparam logic [8:0] IAR_C_ADDR    = 9'h00C;
  localparam logic [8:0] PTRC_LO_ADDR  = 9'h00D;
  localparam logic [8:0] PTRC_SEC_ADDR = 9'h00E;

  // General purpose RAM occupies 80H to FFH of each sector.
  localparam logic [7:0] GP_BASE       = 8'h80;
  localparam logic [7:0] UNUSED_VALUE  = 8'h00;
  localparam logic [7:0] PTR_RESET     = 8'h00;

  typedef enum logic [3:0] {
    PORT_NONE = 4'b0001,
    PORT_A    = 4'b0010,
    PORT_B    = 4'b0100,
    PORT_C    = 4'b1000
  } port_t;

endpackage

// ---- src/indirect_access.sv ----
/*
  Indirect addressing unit: three virtual ports, five pointer registers and
  the sectored general purpose RAM behind them.
  Assumes the core issues one access per cycle on reqValid with a 9-bit
  address (sector bit, then byte) and takes read data one cycle later.
*/
module indirect_access
  import indirect_access_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [8:0]  reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             rspValid,
  output logic      [7:0]  rspData,
  output logic      [8:0]  lastTarget,
  output logic      [7:0]  sector0Pointer,
  output logic      [7:0]  pointerBLow,
  output logic      [7:0]  pointerBSector,
  output logic      [7:0]  pointerCLow,
  output logic      [7:0]  pointerCSector
);

  function automatic port_t portOf(input logic [8:0] a);
    case (a)
      IAR_A_ADDR: portOf = PORT_A;
      IAR_B_ADDR: portOf = PORT_B;
      IAR_C_ADDR: portOf = PORT_C;
      default:    portOf = PORT_NONE;
    endcase
  endfunction

  function automatic logic isGp(input logic [7:0] sec, input logic [7:0] low);
    isGp = (sec < 8'(SECTOR_COUNT)) && (low >= GP_BASE);
  endfunction

  port_t      reqPort;
  logic [7:0] targetSec;
  logic [7:0] targetLow;
  logic [8:0] targetAddr;
  logic       targetIsIar;
  logic       targetIsGp;
  logic       doWrite;
  logic [7:0] ramData;
  logic [7:0] next_rspData;

  // The redirected address is pure logic so it is ready in the access cycle.
  always_comb begin
    reqPort = portOf(reqAddr);
    case (reqPort)
      PORT_A: begin
        targetSec = 8'h00;
        targetLow = sector0Pointer;
      end
      PORT_B: begin
        targetSec = pointerBSector;
        targetLow = pointerBLow;
      end
      PORT_C: begin
        targetSec = pointerCSector;
        targetLow = pointerCLow;
      end
      PORT_NONE: begin
        targetSec = {7'h00, reqAddr[8]};
        targetLow = reqAddr[7:0];
      end
      default: begin
        targetSec = 8'h00;
        targetLow = 8'h00;
      end
    endcase
  end

  // A sector byte beyond the last sector keeps only its low bit here, but
  // isGp flags it so such an access is treated as unused.
  assign targetAddr  = {targetSec[0], targetLow};
  assign targetIsGp  = isGp(targetSec, targetLow);
  // A pointer that names an indirect port makes the access hit the port
  // itself, which has no storage.
  assign targetIsIar = (targetSec == 8'h00) && (portOf(targetAddr) != PORT_NONE);
  assign doWrite     = reqValid && reqWrite && !targetIsIar;

  function automatic logic ptrHit(input logic [8:0] t, input logic [8:0] p,
                                  input logic [7:0] sec);
    ptrHit = (sec == 8'h00) && (t == p);
  endfunction

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sector0Pointer <= PTR_RESET;
    end else if (doWrite && ptrHit(targetAddr, PTR0_ADDR, targetSec)) begin
      sector0Pointer <= reqData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pointerBLow <= PTR_RESET;
    end else if (doWrite && ptrHit(targetAddr, PTRB_LO_ADDR, targetSec)) begin
      pointerBLow <= reqData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pointerBSector <= PTR_RESET;
    end else if (doWrite && ptrHit(targetAddr, PTRB_SEC_ADDR, targetSec)) begin
      pointerBSector <= reqData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pointerCLow <= PTR_RESET;
    end else if (doWrite && ptrHit(targetAddr, PTRC_LO_ADDR, targetSec)) begin
      pointerCLow <= reqData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pointerCSector <= PTR_RESET;
    end else if (doWrite && ptrHit(targetAddr, PTRC_SEC_ADDR, targetSec)) begin
      pointerCSector <= reqData;
    end
  end

  sector_ram sector_ram_i (
    .clk        (clk),
    .writeEn    (doWrite && targetIsGp),
    .writeIndex ({targetSec[0], targetLow[6:0]}),
    .writeData  (reqData),
    .readIndex  ({targetSec[0], targetLow[6:0]}),
    .readData   (ramData)
  );

  always_comb begin
    next_rspData = UNUSED_VALUE;
    if (targetIsIar) begin
      next_rspData = UNUSED_VALUE;
    end else if (targetIsGp) begin
      next_rspData = ramData;
    end else if (targetSec == 8'h00) begin
      case (targetAddr)
        PTR0_ADDR:     next_rspData = sector0Pointer;
        PTRB_LO_ADDR:  next_rspData = pointerBLow;
        PTRB_SEC_ADDR: next_rspData = pointerBSector;
        PTRC_LO_ADDR:  next_rspData = pointerCLow;
        PTRC_SEC_ADDR: next_rspData = pointerCSector;
        default:       next_rspData = UNUSED_VALUE;
      endcase
    end
  end

  // Registering the answer costs a cycle of latency but keeps every output
  // glitch free for the core.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspData  <= UNUSED_VALUE;
    end else begin
      rspValid <= reqValid && !reqWrite;
      rspData  <= (reqValid && !reqWrite) ? next_rspData : UNUSED_VALUE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lastTarget <= 9'h000;
    end else if (reqValid) begin
      lastTarget <= targetAddr;
    end
  end

  sequence s_gp_write;
    reqValid && reqWrite && portOf(reqAddr) == PORT_NONE && reqAddr[7:0] >= GP_BASE;
  endsequence

  sequence s_same_read;
    reqValid && !reqWrite && reqAddr == $past(reqAddr);
  endsequence

  sequence s_read_req;
    reqValid && !reqWrite;
  endsequence

  property p_iar_reads_zero;
    @(posedge clk) disable iff (!nrst)
      reqValid && !reqWrite && targetIsIar |=> rspValid && rspData == 8'h00;
  endproperty
  a_iar_reads_zero: assert property (p_iar_reads_zero)
    else $error("Read of an indirect port location did not return zero.");

  property p_iar_write_void;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqWrite && targetIsIar |=>
        $stable({sector0Pointer, pointerBLow, pointerBSector, pointerCLow, pointerCSector});
  endproperty
  a_iar_write_void: assert property (p_iar_write_void)
    else $error("Write to an indirect port location changed a pointer.");

  property p_port_a_target;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqAddr == IAR_A_ADDR |=>
        lastTarget == {1'b0, $past(sector0Pointer)};
  endproperty
  a_port_a_target: assert property (p_port_a_target)
    else $error("Port a did not redirect into sector 0 at its pointer.");

  property p_port_b_target;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqAddr == IAR_B_ADDR |=>
        lastTarget == {$past(pointerBSector[0]), $past(pointerBLow)};
  endproperty
  a_port_b_target: assert property (p_port_b_target)
    else $error("Port b did not redirect to its sector and low pointer.");

  property p_port_c_target;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqAddr == IAR_C_ADDR |=>
        lastTarget == {$past(pointerCSector[0]), $past(pointerCLow)};
  endproperty
  a_port_c_target: assert property (p_port_c_target)
    else $error("Port c did not redirect to its sector and low pointer.");

  property p_ptr_write;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqWrite && reqAddr == PTRB_SEC_ADDR |=>
        pointerBSector == $past(reqData) ##1 ($stable(pointerBSector) || $past(reqValid));
  endproperty
  a_ptr_write: assert property (p_ptr_write)
    else $error("Direct write to a pointer did not store the data.");

  property p_ptr_read;
    @(posedge clk) disable iff (!nrst)
      reqValid && !reqWrite && reqAddr == PTR0_ADDR |=>
        rspValid && rspData == sector0Pointer;
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("Direct read of a pointer did not return its value.");

  property p_unused_zero;
    @(posedge clk) disable iff (!nrst)
      reqValid && !reqWrite && reqAddr == 9'h005 |=> rspData == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("Read of an unused location did not return zero.");

  property p_gp_roundtrip;
    @(posedge clk) disable iff (!nrst)
      s_gp_write ##1 s_same_read |=> rspData == $past(reqData, 2);
  endproperty
  a_gp_roundtrip: assert property (p_gp_roundtrip)
    else $error("Direct RAM write then read gave different data.");

  property p_same_cycle_target;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqWrite && reqAddr == IAR_B_ADDR && pointerBSector == 8'h01 &&
        pointerBLow >= GP_BASE
      ##1 reqValid && !reqWrite && reqAddr == {1'b1, $past(pointerBLow)}
      |=> rspData == $past(reqData, 2);
  endproperty
  a_same_cycle_target: assert property (p_same_cycle_target)
    else $error("Indirect write through port b missed the sector 1 location.");

  property p_read_answer;
    @(posedge clk) disable iff (!nrst)
      s_read_req |=> rspValid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("A read request got no answer in the next cycle.");

  property p_rsp_idle;
    @(posedge clk) disable iff (!nrst)
      !(reqValid && !reqWrite) |=> !rspValid && rspData == UNUSED_VALUE;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle)
    else $error("An answer appeared without a read request.");

  property p_port_a_sector;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqAddr == IAR_A_ADDR |=> !lastTarget[8];
  endproperty
  a_port_a_sector: assert property (p_port_a_sector)
    else $error("Port a reached a location outside sector 0.");

  property p_direct_target;
    @(posedge clk) disable iff (!nrst)
      reqValid && portOf(reqAddr) == PORT_NONE |=> lastTarget == $past(reqAddr);
  endproperty
  a_direct_target: assert property (p_direct_target)
    else $error("A direct access was not taken at its own address.");

  property p_ptr0_write;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqWrite && reqAddr == PTR0_ADDR |=> sector0Pointer == $past(reqData);
  endproperty
  a_ptr0_write: assert property (p_ptr0_write)
    else $error("Direct write to the sector-zero pointer did not store the data.");

  property p_far_sector_void;
    @(posedge clk) disable iff (!nrst)
      reqValid && !reqWrite && reqAddr == IAR_C_ADDR && pointerCSector >= 8'h02 |=>
        rspValid && rspData == UNUSED_VALUE;
  endproperty
  a_far_sector_void: assert property (p_far_sector_void)
    else $error("Read through port c beyond the last sector did not return zero.");

  property p_sector1_low_void;
    @(posedge clk) disable iff (!nrst)
      reqValid && !reqWrite && reqAddr[8] && reqAddr[7:0] < GP_BASE |=>
        rspData == UNUSED_VALUE;
  endproperty
  a_sector1_low_void: assert property (p_sector1_low_void)
    else $error("Read of an unused sector 1 location did not return zero.");

endmodule

// ---- src/sector_ram.sv ----
/*
  General purpose data memory: 128 bytes in each of the two sectors.
  Assumes the caller has already checked that the address lies in RAM.
*/
module sector_ram
  import indirect_access_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        writeEn,
  input  wire logic [7:0]  writeIndex,
  input  wire logic [7:0]  writeData,
  input  wire logic [7:0]  readIndex,
  output logic      [7:0]  readData
);

  logic [7:0] cells [0:(SECTOR_COUNT*128)-1];

  // Contents are undefined after reset, as for the real RAM.
  always_ff @(posedge clk) begin
    if (writeEn) begin
      cells[writeIndex] <= writeData;
    end
  end

  assign readData = cells[readIndex];

endmodule

// ---- test/indirect_access_tb_top.sv ----
/*
  Self-checking bench for the indirect addressing unit: pointers, three
  virtual ports, sectored RAM and unused locations.
  Assumes one access per cycle and read data exactly one cycle after the request.
*/
module indirect_access_tb_top
  import indirect_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nFail++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [8:0]  reqAddr = 9'h000;
  logic [7:0]  reqData = 8'h00;
  logic        rspValid;
  logic [7:0]  rspData;
  logic [8:0]  lastTarget;
  logic [7:0]  sector0Pointer;
  logic [7:0]  pointerBLow;
  logic [7:0]  pointerBSector;
  logic [7:0]  pointerCLow;
  logic [7:0]  pointerCSector;
  int          nFail = 0;
  int          checksDone = 0;
  int          cycles = 0;
  int unsigned seedV;
  logic [7:0]  expV;
  logic [7:0]  expQ[$];
  logic [8:0]  ptrAddr[5] = '{PTR0_ADDR, PTRB_LO_ADDR, PTRB_SEC_ADDR, PTRC_LO_ADDR, PTRC_SEC_ADDR};
  logic [7:0]  ptrVal[5] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5};
  logic [8:0]  unusedAddr[5] = '{9'h00B, 9'h050, 9'h105, 9'h17F, 9'h005};
  logic [8:0]  ra;
  logic [7:0]  rd8;
  logic [39:0] ptrsAll;

  indirect_access indirect_access_i (
    .clk(clk), .nrst(nrst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .lastTarget(lastTarget),
    .sector0Pointer(sector0Pointer), .pointerBLow(pointerBLow),
    .pointerBSector(pointerBSector), .pointerCLow(pointerCLow),
    .pointerCSector(pointerCSector)
  );

  assign ptrsAll = {sector0Pointer, pointerBLow, pointerBSector, pointerCLow, pointerCSector};

  always #25 clk = ~clk;

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Called at a falling edge; the request is taken at the next rising edge.
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr  = a;
    reqData  = d;
    @(negedge clk);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  // The expected byte is noted before the request so the monitor finds it in order.
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    expQ.push_back(e);
    acc(1'b0, a, 8'($urandom));
  endtask

  task automatic idle(input int n);
    reqValid = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  always @(negedge clk) begin
    if (nrst && rspValid) begin
      if (expQ.size() == 0) begin
        `CHK("rspValidSpurious", 1'b0, rspValid)
      end else begin
        expV = expQ.pop_front();
        `CHK("rspData", expV, rspData)
      end
    end else if (nrst) begin
      `CHK("rspDataIdle", 8'h00, rspData)
      `CHK("rspValidIdle", 1'b0, rspValid)
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      nFail++;
      finishTest();
    end
  end

  initial begin
    seedV = $urandom(9514);
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    `CHK("ptrsAfterReset", 40'h0, ptrsAll)
    `CHK("lastTargetReset", 9'h000, lastTarget)
    for (int i = 0; i < 5; i++) wr(ptrAddr[i], ptrVal[i]);
    `CHK("ptrsWritten", 40'hA1B2C3D4E5, ptrsAll)
    for (int i = 0; i < 5; i++) rd(ptrAddr[i], ptrVal[i]);
    wr(PTR0_ADDR, 8'h90);
    wr(9'h190, 8'hC3);
    wr(IAR_A_ADDR, 8'h3C);
    `CHK("lastTargetA", 9'h090, lastTarget)
    rd(9'h090, 8'h3C);
    rd(IAR_A_ADDR, 8'h3C);
    rd(9'h190, 8'hC3);
    rd8 = 8'($urandom);
    wr(9'h1F0, rd8);
    rd(9'h1F0, rd8);
    wr(9'h0A5, 8'h11);
    wr(PTRB_SEC_ADDR, 8'h01);
    wr(PTRB_LO_ADDR, 8'hA5);
    wr(IAR_B_ADDR, 8'h5A);
    `CHK("lastTargetB", 9'h1A5, lastTarget)
    rd(9'h1A5, 8'h5A);
    rd(9'h0A5, 8'h11);
    rd(IAR_B_ADDR, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      ra  = {1'($urandom), 1'b1, 7'($urandom)};
      rd8 = 8'($urandom);
      wr(ra, rd8);
      wr(PTRC_SEC_ADDR, {7'h00, ra[8]});
      wr(PTRC_LO_ADDR, ra[7:0]);
      rd(IAR_C_ADDR, rd8);
      rd(ra, rd8);
    end
    // Port a aimed at itself and port b aimed at port c: both must stay empty.
    wr(PTR0_ADDR, 8'h00);
    wr(PTRB_SEC_ADDR, 8'h00);
    wr(PTRB_LO_ADDR, 8'h0C);
    wr(IAR_A_ADDR, 8'h77);
    wr(IAR_B_ADDR, 8'h44);
    rd(IAR_A_ADDR, 8'h00);
    rd(IAR_B_ADDR, 8'h00);
    `CHK("ptrsKept", 24'h000C00, {sector0Pointer, pointerBLow, pointerBSector})
    wr(PTRC_SEC_ADDR, 8'h02);
    rd(IAR_C_ADDR, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(unusedAddr[i], 8'hFF);
      rd(unusedAddr[i], 8'h00);
    end
    idle(3);
    `CHK("pendingReads", 0, expQ.size())
    nrst = 1'b0;
    idle(2);
    nrst = 1'b1;
    `CHK("ptrsAfterReset2", 40'h0, ptrsAll)
    rd(PTRC_SEC_ADDR, 8'h00);
    idle(3);
    `CHK("pendingReads2", 0, expQ.size())
    finishTest();
  end

endmodule
